// >>> hw/mcs_clock_selector.sv
// clock source selection, dividers and register slave of the mcu clock block
`timescale 1ns/10ps
// Overview of operation
// - internal 1 MHz and external 32768 Hz sources
// - master clock: internal, external, or external halved
// - secondary clock is master or master over four
// - control pair gates the two oscillators
// - sleep stops both oscillators
// - instruction cycle divides master by 6.5/12.5/2/4
// - N-bit conversion gets two-to-the-N sample clocks
// - ADC sample clock is master over 25 or 50
// - beeper from secondary or external over eight
// - seven consumer outputs from six dividers; timer and LCD share one clock
// - doubler clock from master or external over 32
// - chopper signal constant or secondary over 500/1000
// - timer and LCD clock selection
`include "mcs_defs.svh"
module mcs_clock_selector
    import mcs_pkg::*;
#(
    parameter int ADC_CW = 17
) (
    // clock and reset
    input logic clk_i,
    input logic rst_i,
    // wishbone slave
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic [7:0] wb_adr_i,
    input logic [3:0] wb_sel_i,
    input logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // oscillators and sleep
    input logic int_osc_clk_i,
    input logic ext_osc_clk_i,
    input logic sleep_i,
    output logic int_osc_en_o,
    output logic ext_osc_en_o,
    // master and secondary ticks
    output logic master_tick_o,
    output logic secondary_tick_o,
    // consumer clocks
    output logic doubler_clk_o,
    output logic adc_clk_o,
    output logic icyc_clk_o,
    output logic chopper_ctl_o,
    output logic beep_clk_o,
    output logic timer_clk_o,
    output logic lcd_clk_o,
    // adc conversion sequencing
    input logic adc_start_i,
    input logic [4:0] adc_res_i,
    output logic adc_busy_o,
    output logic adc_done_o
);

    // byte address match for a register index
    function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] idx);
        reg_hit = (adr == {idx[5:0], 2'b00});
    endfunction : reg_hit

    logic [7:0] csel_reg;
    logic [7:0] pctl_reg;
    logic ack;
    logic int_q;
    logic ext_q;
    logic half_ph;
    logic [1:0] div4_cnt;
    logic dbl_out;
    logic chop_out;
    mcs_adc_state_t adc_state;
    logic [ADC_CW-1:0] adc_cnt;
    logic icyc_clk;
    logic adc_clk;
    logic adc_tick;
    logic dbl_clk;
    logic beep_clk;
    logic chop_clk;
    logic tlcd_clk;

    // field decode
    wire ext_sel = csel_reg[`MCS_CSEL_EXT_SEL];
    wire div4_sel = csel_reg[`MCS_CSEL_DIV4];
    wire fast_sel = csel_reg[`MCS_CSEL_FAST];
    wire halve_sel = csel_reg[`MCS_CSEL_HALVE];
    wire tlcd_sel = csel_reg[`MCS_CSEL_TLCD];
    wire osc_lo = csel_reg[`MCS_CSEL_OSC_LO];
    wire osc_hi = csel_reg[`MCS_CSEL_OSC_HI];
    wire pump_sel = pctl_reg[`MCS_PCTL_PUMP];
    wire beep_sel = pctl_reg[`MCS_PCTL_BEEP];
    wire [1:0] chop_sel = pctl_reg[`MCS_PCTL_CHOP_HI:`MCS_PCTL_CHOP_LO];
    wire doubler_en = pctl_reg[`MCS_PCTL_DBL_EN];

    // bus decode; reads of unmapped words return zero, writes there are dropped
    wire bus_req = wb_cyc_i & wb_stb_i;
    wire hit_csel = reg_hit(wb_adr_i, `MCS_IDX_CSEL);
    wire hit_pctl = reg_hit(wb_adr_i, `MCS_IDX_PCTL);
    wire hit_stat = reg_hit(wb_adr_i, `MCS_IDX_STAT);
    wire wr_lane = bus_req & wb_we_i & ack & wb_sel_i[0];
    wire [7:0] stat_val = {4'h0, sleep_i, adc_busy_o, ext_osc_en_o, int_osc_en_o};
    wire [7:0] rd_byte = hit_csel ? csel_reg :
                         hit_pctl ? pctl_reg :
                         hit_stat ? stat_val : 8'h00;
    // unwritable bits are masked here so they always read back as zero
    wire [7:0] next_csel = (wr_lane & hit_csel) ? (wb_dat_i[7:0] & `MCS_CSEL_WMASK) : csel_reg;
    wire [7:0] next_pctl = (wr_lane & hit_pctl) ? (wb_dat_i[7:0] & `MCS_PCTL_WMASK) : pctl_reg;

    // one wait state: ack rises the cycle after the request, write lands with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            wb_dat_o <= 32'h00000000;
            csel_reg <= `MCS_CSEL_RST;
            pctl_reg <= `MCS_PCTL_RST;
        end else begin
            ack <= bus_req & ~ack;
            if (bus_req & ~ack) begin
                wb_dat_o <= {24'h000000, rd_byte};
            end
            csel_reg <= next_csel;
            pctl_reg <= next_pctl;
        end
    end
    assign wb_ack_o = ack;

    // oscillator gating: 00 both, 10 external only, 01 and 11 internal only
    wire next_int_en = ~sleep_i & ~(osc_hi & ~osc_lo);
    wire next_ext_en = ~sleep_i & ~osc_lo;

    // source edges count only while that oscillator is enabled
    wire int_tick = int_osc_clk_i & ~int_q & int_osc_en_o;
    wire ext_tick = ext_osc_clk_i & ~ext_q & ext_osc_en_o;
    // switching to a still-settling oscillator is the software's hazard
    wire master_tick = ext_sel ? (ext_tick & (~halve_sel | half_ph)) : int_tick;
    wire sec_tick = master_tick & (~div4_sel | (div4_cnt == 2'h3));

    // sources and prescalers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_q <= 1'b0;
            ext_q <= 1'b0;
            half_ph <= 1'b0;
            div4_cnt <= 2'h0;
            int_osc_en_o <= 1'b0;
            ext_osc_en_o <= 1'b0;
            master_tick_o <= 1'b0;
            secondary_tick_o <= 1'b0;
        end else begin
            int_q <= int_osc_clk_i;
            ext_q <= ext_osc_clk_i;
            int_osc_en_o <= next_int_en;
            ext_osc_en_o <= next_ext_en;
            master_tick_o <= master_tick;
            secondary_tick_o <= sec_tick;
            if (ext_tick) begin
                half_ph <= ~half_ph;
            end
            if (master_tick) begin
                div4_cnt <= div4_cnt + 2'h1;
            end
        end
    end

    // ratio selection for each consumer
    wire [11:0] icyc_d2 = fast_sel ? (div4_sel ? `MCS_D2_ICYC_11 : `MCS_D2_ICYC_10) :
                                     (div4_sel ? `MCS_D2_ICYC_01 : `MCS_D2_ICYC_00);
    wire [11:0] adc_d2 = div4_sel ? `MCS_D2_ADC_50 : `MCS_D2_ADC_25;
    wire dbl_src = ext_sel ? ext_tick : master_tick;
    wire [11:0] dbl_d2 = ext_sel ? `MCS_D2_EXT_32 :
                         pump_sel ? `MCS_D2_DBL_100 : `MCS_D2_DBL_200;
    wire beep_src = (beep_sel & ext_sel) ? ext_tick : sec_tick;
    wire [11:0] beep_d2 = ~beep_sel ? `MCS_D2_BEEP_250 :
                          ext_sel ? `MCS_D2_EXT_8 : `MCS_D2_BEEP_375;
    wire [11:0] chop_d2 = chop_sel[0] ? `MCS_D2_CLK_1000 : `MCS_D2_CLK_500;
    wire tlcd_src = tlcd_sel ? ext_tick : sec_tick;
    wire [11:0] tlcd_d2 = tlcd_sel ? `MCS_D2_EXT_32 : `MCS_D2_CLK_1000;

    // one divider per consumer clock
    mcs_divider #(.W(12)) u_icyc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(master_tick),
        .div2_i(icyc_d2),
        .clk_o(icyc_clk),
        .tick_o()
    );
    mcs_divider #(.W(12)) u_adc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(master_tick),
        .div2_i(adc_d2),
        .clk_o(adc_clk),
        .tick_o(adc_tick)
    );
    mcs_divider #(.W(12)) u_dbl (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(dbl_src),
        .div2_i(dbl_d2),
        .clk_o(dbl_clk),
        .tick_o()
    );
    mcs_divider #(.W(12)) u_beep (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(beep_src),
        .div2_i(beep_d2),
        .clk_o(beep_clk),
        .tick_o()
    );
    mcs_divider #(.W(12)) u_chop (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(sec_tick),
        .div2_i(chop_d2),
        .clk_o(chop_clk),
        .tick_o()
    );
    mcs_divider #(.W(12)) u_tlcd (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tlcd_src),
        .div2_i(tlcd_d2),
        .clk_o(tlcd_clk),
        .tick_o()
    );

    // consumer outputs; doubler is held low while disabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dbl_out <= 1'b0;
            chop_out <= 1'b0;
        end else begin
            dbl_out <= dbl_clk & doubler_en;
            chop_out <= chop_sel[1] ? chop_clk : chop_sel[0];
        end
    end
    assign doubler_clk_o = dbl_out;
    assign adc_clk_o = adc_clk;
    assign icyc_clk_o = icyc_clk;
    assign chopper_ctl_o = chop_out;
    assign beep_clk_o = beep_clk;
    assign timer_clk_o = tlcd_clk;
    assign lcd_clk_o = tlcd_clk;

    // conversion length; resolutions above MCS_ADC_MAX_N (16 bits) are clamped to it
    wire [4:0] adc_n = (adc_res_i > `MCS_ADC_MAX_N) ? `MCS_ADC_MAX_N : adc_res_i;
    wire [ADC_CW-1:0] adc_target = {{(ADC_CW - 1){1'b0}}, 1'b1} << adc_n;
    wire [ADC_CW-1:0] adc_cnt_inc = adc_cnt + {{(ADC_CW - 1){1'b0}}, 1'b1};
    wire adc_last = adc_tick & (adc_cnt_inc == adc_target);

    // sample-clock counter for one conversion; a start while busy is ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adc_state <= MCS_ADC_IDLE;
            adc_cnt <= {ADC_CW{1'b0}};
            adc_done_o <= 1'b0;
        end else begin
            adc_done_o <= 1'b0;
            case (adc_state)
                MCS_ADC_IDLE: begin
                    if (adc_start_i) begin
                        adc_cnt <= {ADC_CW{1'b0}};
                        adc_state <= MCS_ADC_RUN;
                    end
                end
                MCS_ADC_RUN: begin
                    if (adc_tick) begin
                        adc_cnt <= adc_cnt_inc;
                    end
                    if (adc_last) begin
                        adc_done_o <= 1'b1;
                        adc_state <= MCS_ADC_IDLE;
                    end
                end
                default: begin
                    adc_state <= MCS_ADC_IDLE;
                end
            endcase
        end
    end
    assign adc_busy_o = (adc_state == MCS_ADC_RUN);

    property p_sleep_stop;
        @(posedge clk_i) disable iff (rst_i) sleep_i |=> !int_osc_en_o && !ext_osc_en_o;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("oscillator on in sleep");

    property p_ext_only;
        @(posedge clk_i) disable iff (rst_i)
            !sleep_i && osc_hi && !osc_lo |=> !int_osc_en_o && ext_osc_en_o;
    endproperty
    a_ext_only: assert property (p_ext_only) else $error("external-only gating wrong");

    property p_int_only;
        @(posedge clk_i) disable iff (rst_i)
            !sleep_i && osc_lo |=> int_osc_en_o && !ext_osc_en_o;
    endproperty
    a_int_only: assert property (p_int_only) else $error("internal-only gating wrong");

    property p_both_on;
        @(posedge clk_i) disable iff (rst_i)
            !sleep_i && !osc_hi && !osc_lo |=> int_osc_en_o && ext_osc_en_o;
    endproperty
    a_both_on: assert property (p_both_on) else $error("both oscillators not enabled");

    property p_ext_direct;
        @(posedge clk_i) disable iff (rst_i)
            ext_sel && !halve_sel && ext_osc_en_o && ext_osc_clk_i && !ext_q
            |=> master_tick_o;
    endproperty
    a_ext_direct: assert property (p_ext_direct) else $error("external edge lost");

    property p_sec_equal;
        @(posedge clk_i) disable iff (rst_i) !div4_sel |=> secondary_tick_o == master_tick_o;
    endproperty
    a_sec_equal: assert property (p_sec_equal) else $error("secondary differs from master");

    property p_dbl_off;
        @(posedge clk_i) disable iff (rst_i) !doubler_en ##1 !doubler_en |-> !doubler_clk_o;
    endproperty
    a_dbl_off: assert property (p_dbl_off) else $error("doubler clock while disabled");

    property p_chop_const;
        @(posedge clk_i) disable iff (rst_i)
            chop_sel == 2'b01 ##1 chop_sel == 2'b01 |-> chopper_ctl_o;
    endproperty
    a_chop_const: assert property (p_chop_const) else $error("chopper not held high");

    property p_bus_ack;
        @(posedge clk_i) disable iff (rst_i) bus_req && !ack |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("bus answer timing wrong");

    property p_adc_start;
        @(posedge clk_i) disable iff (rst_i)
            adc_start_i && !adc_busy_o |=> adc_busy_o && adc_cnt == {ADC_CW{1'b0}};
    endproperty
    a_adc_start: assert property (p_adc_start) else $error("conversion did not start");

endmodule : mcs_clock_selector

// >>> hw/mcs_divider.sv
// fractional clock divider driven by a tick enable
`timescale 1ns/10ps
module mcs_divider #(
    parameter int W = 12
) (
    // clock and reset
    input logic clk_i,
    input logic rst_i,
    // source tick and ratio, twice the divisor
    input logic tick_i,
    input logic [W-1:0] div2_i,
    // divided level and period-start pulse
    output logic clk_o,
    output logic tick_o
);

    logic [W-1:0] acc;
    logic [W-1:0] div2_q;

    // step by two half units per tick; wrap keeps the remainder so odd
    // ratios alternate adjacent period lengths
    wire [W:0] sum = {1'b0, acc} + {{(W - 1){1'b0}}, 2'b10};
    wire wrap = tick_i & (sum >= {1'b0, div2_q});
    wire [W:0] rem = sum - {1'b0, div2_q};
    wire [W-1:0] next_acc = wrap ? rem[W-1:0] : sum[W-1:0];
    wire next_clk = ({next_acc, 1'b0} < {1'b0, div2_q});

    // ratio is taken only at a wrap, so a new setting never cuts a period short
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc <= {W{1'b0}};
            div2_q <= {{(W - 2){1'b0}}, 2'b10};
            clk_o <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= wrap;
            if (tick_i) begin
                acc <= next_acc;
                clk_o <= next_clk;
            end
            if (wrap) begin
                div2_q <= div2_i;
            end
        end
    end

    property p_acc_bound;
        @(posedge clk_i) disable iff (rst_i) acc < div2_q;
    endproperty
    a_acc_bound: assert property (p_acc_bound) else $error("divider phase overran");

    property p_wrap_pulse;
        @(posedge clk_i) disable iff (rst_i) wrap |=> tick_o ##1 !tick_o || wrap;
    endproperty
    a_wrap_pulse: assert property (p_wrap_pulse) else $error("period pulse wrong");

endmodule : mcs_divider

// >>> pkg/mcs_defs.svh
// register offsets, field positions, reset values and division ratios of the clock block
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define MCS_IDX_CSEL 8'h14
`define MCS_IDX_PCTL 8'h15
`define MCS_IDX_STAT 8'h16

// reset values and writable-bit masks
`define MCS_CSEL_RST 8'h00
`define MCS_PCTL_RST 8'h00
`define MCS_CSEL_WMASK 8'hEF
`define MCS_PCTL_WMASK 8'h4F

// clock_select_reg fields
`define MCS_CSEL_EXT_SEL 0
`define MCS_CSEL_DIV4 1
`define MCS_CSEL_FAST 2
`define MCS_CSEL_HALVE 3
`define MCS_CSEL_TLCD 5
`define MCS_CSEL_OSC_LO 6
`define MCS_CSEL_OSC_HI 7

// peripheral_clock_ctl fields
`define MCS_PCTL_PUMP 0
`define MCS_PCTL_BEEP 1
`define MCS_PCTL_CHOP_LO 2
`define MCS_PCTL_CHOP_HI 3
`define MCS_PCTL_DBL_EN 6

// division ratios held as twice the divisor, so halves are exact
`define MCS_D2_ICYC_00 12'h00D
`define MCS_D2_ICYC_01 12'h019
`define MCS_D2_ICYC_10 12'h004
`define MCS_D2_ICYC_11 12'h008
`define MCS_D2_ADC_25 12'h032
`define MCS_D2_ADC_50 12'h064
`define MCS_D2_DBL_200 12'h190
`define MCS_D2_DBL_100 12'h0C8
`define MCS_D2_EXT_32 12'h040
`define MCS_D2_EXT_8 12'h010
`define MCS_D2_BEEP_250 12'h1F4
`define MCS_D2_BEEP_375 12'h2EE
`define MCS_D2_CLK_500 12'h3E8
`define MCS_D2_CLK_1000 12'h7D0

// largest conversion resolution in bits
`define MCS_ADC_MAX_N 5'h10

`endif

// >>> pkg/mcs_pkg.sv
// types shared by the clock block modules
package mcs_pkg;

    // divisor carried as twice its value
    typedef logic [11:0] mcs_div2_t;

    // adc conversion sequencer
    typedef enum logic [0:0] {
        MCS_ADC_IDLE = 1'b0,
        MCS_ADC_RUN = 1'b1
    } mcs_adc_state_t;

endpackage : mcs_pkg

// >>> testbench/mcs_clock_selector_tb.sv
// self-checking bench of the clock block: registers, oscillator gating, dividers, adc
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module mcs_clock_selector_tb;
    // stimulus
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic sleep_i = 1'b0;
    logic adc_start_i = 1'b0;
    logic [4:0] adc_res_i = 5'h00;
    // observed
    logic [31:0] wb_dat_o;
    logic wb_ack_o, int_osc_clk_i, ext_osc_clk_i, int_osc_en_o, ext_osc_en_o;
    logic master_tick_o, secondary_tick_o, doubler_clk_o, adc_clk_o, icyc_clk_o;
    logic chopper_ctl_o, beep_clk_o, timer_clk_o, lcd_clk_o, adc_busy_o, adc_done_o;
    wire [8:0] outs = {lcd_clk_o, timer_clk_o, beep_clk_o, chopper_ctl_o, icyc_clk_o,
        adc_clk_o, doubler_clk_o, secondary_tick_o, master_tick_o};
    int errors = 0;
    int num_checks = 0;
    logic [31:0] rd;
    int i;
    int k;
    int c;
    // clock_select, peripheral_ctl, output index, periods, cycles (int 4, ext 6 per edge)
    int rows [0:23][0:4] = '{
        '{8'h00, 8'h00, 0, 4, 16}, '{8'h01, 8'h00, 0, 4, 24},
        '{8'h09, 8'h00, 0, 4, 48}, '{8'h08, 8'h00, 0, 4, 16},
        '{8'h00, 8'h00, 1, 4, 16}, '{8'h02, 8'h00, 1, 4, 64},
        '{8'h00, 8'h00, 4, 2, 52}, '{8'h02, 8'h00, 4, 2, 100},
        '{8'h04, 8'h00, 4, 2, 16}, '{8'h06, 8'h00, 4, 2, 32},
        '{8'h00, 8'h00, 3, 1, 100}, '{8'h02, 8'h00, 3, 1, 200},
        '{8'h00, 8'h00, 6, 1, 1000}, '{8'h00, 8'h02, 6, 1, 1500},
        '{8'h01, 8'h02, 6, 2, 96}, '{8'h01, 8'h00, 6, 1, 1500},
        '{8'h00, 8'h40, 2, 1, 800}, '{8'h00, 8'h41, 2, 1, 400},
        '{8'h01, 8'h40, 2, 2, 384}, '{8'h00, 8'h08, 5, 1, 2000},
        '{8'h00, 8'h0C, 5, 1, 4000}, '{8'h00, 8'h00, 7, 1, 4000},
        '{8'h20, 8'h00, 8, 2, 384}, '{8'h20, 8'h00, 7, 2, 384}};
    logic [1:0] osc_exp [0:3] = '{2'h3, 2'h1, 2'h2, 2'h1};

    always #10 clk_i = ~clk_i;

    mcs_osc_model #(.PI(4), .PE(6)) u_osc (.clk_i(clk_i), .int_en_i(int_osc_en_o),
        .ext_en_i(ext_osc_en_o), .int_clk_o(int_osc_clk_i), .ext_clk_o(ext_osc_clk_i));

    mcs_clock_selector #(.ADC_CW(17)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .int_osc_clk_i(int_osc_clk_i), .ext_osc_clk_i(ext_osc_clk_i), .sleep_i(sleep_i),
        .int_osc_en_o(int_osc_en_o), .ext_osc_en_o(ext_osc_en_o),
        .master_tick_o(master_tick_o), .secondary_tick_o(secondary_tick_o),
        .doubler_clk_o(doubler_clk_o), .adc_clk_o(adc_clk_o), .icyc_clk_o(icyc_clk_o),
        .chopper_ctl_o(chopper_ctl_o), .beep_clk_o(beep_clk_o), .timer_clk_o(timer_clk_o),
        .lcd_clk_o(lcd_clk_o), .adc_start_i(adc_start_i), .adc_res_i(adc_res_i),
        .adc_busy_o(adc_busy_o), .adc_done_o(adc_done_o));

    // verdict and end of run
    task summarize;
        if (errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // one classic cycle; request held until the edge that sees ack
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int t;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        for (t = 0; t < 50; t++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (t == 50) begin
            errors++;
            summarize();
        end
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, {24'h000000, d}, 4'hF);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
        wb(1'b0, a, 32'h00000000, 4'hF);
        `CHK(n, e, rd)
    endtask : rdchk

    // cycles up to the next rising edge of one output, bounded
    task automatic rise(input int idx, output int n);
        logic p;
        p = outs[idx];
        for (n = 1; n < 20000; n++) begin
            @(posedge clk_i);
            if (outs[idx] === 1'b1 && p === 1'b0) break;
            p = outs[idx];
        end
        if (n == 20000) begin
            errors++;
            summarize();
        end
    endtask : rise

    // two settling periods, since a new ratio waits for the wrap, then whole periods
    task automatic meas(input int idx, input int np, input int e, input string nm);
        int n;
        int tot;
        tot = 0;
        rise(idx, n);
        rise(idx, n);
        repeat (np) begin
            rise(idx, n);
            tot += n;
        end
        `CHK(nm, e, tot)
    endtask : meas

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(8'h50, 32'h00000000, "csel reset");
        rdchk(8'h54, 32'h00000000, "pctl reset");
        rdchk(8'h58, 32'h00000003, "status reset");
        rdchk(8'h60, 32'h00000000, "unmapped");
        wr(8'h50, 8'hFF);
        rdchk(8'h50, 32'h000000EF, "csel rw");
        wb(1'b1, 8'h50, 32'h00000000, 4'h0);
        rdchk(8'h50, 32'h000000EF, "sel dropped");
        wr(8'h54, 8'hFF);
        rdchk(8'h54, 32'h0000004F, "pctl rw");
        wr(8'h60, 8'h55);
        wr(8'h54, 8'h04);
        repeat (3) @(posedge clk_i);
        `CHK("chop one", 1'b1, chopper_ctl_o)
        wr(8'h54, 8'h00);
        repeat (3) @(posedge clk_i);
        `CHK("chop zero", 1'b0, chopper_ctl_o)
        // oscillator gating by the control pair, then by sleep
        for (k = 0; k < 4; k++) begin
            wr(8'h50, 8'(k << 6));
            repeat (3) @(posedge clk_i);
            `CHK("osc en", osc_exp[k], {ext_osc_en_o, int_osc_en_o})
        end
        sleep_i <= 1'b1;
        rdchk(8'h58, 32'h00000008, "sleep status");
        `CHK("sleep en", 2'h0, {ext_osc_en_o, int_osc_en_o})
        sleep_i <= 1'b0;
        // ext master chosen only while the ext source already runs
        for (i = 0; i < 24; i++) begin
            wr(8'h50, 8'(rows[i][0]));
            wr(8'h54, 8'(rows[i][1]));
            meas(rows[i][2], rows[i][3], rows[i][4], $sformatf("row%0d", i));
        end
        // conversions of 2 and 3 bits, fast cycle kept off, a start while busy refused
        wr(8'h50, 8'h00);
        wr(8'h54, 8'h00);
        for (k = 2; k < 4; k++) begin
            @(posedge clk_i);
            adc_res_i <= 5'(k);
            adc_start_i <= 1'b1;
            @(posedge clk_i);
            adc_start_i <= 1'b0;
            @(posedge clk_i);
            `CHK("adc busy", 1'b1, adc_busy_o)
            adc_start_i <= 1'b1;
            for (c = 0; c < 2000; c++) begin
                @(posedge clk_i);
                adc_start_i <= 1'b0;
                if (adc_done_o === 1'b1) break;
            end
            if (c == 2000) begin
                errors++;
                summarize();
            end
            `CHK("adc time", 1'b1, c > (2 ** k - 1) * 100 - 4 && c < 2 ** k * 100 + 4)
            repeat (2) @(posedge clk_i);
            `CHK("adc idle", 1'b0, adc_busy_o)
        end
        summarize();
    end
endmodule : mcs_clock_selector_tb

// >>> testbench/mcs_osc_model.sv
// oscillator source model feeding the clock block
`timescale 1ns/10ps
module mcs_osc_model #(
    parameter int PI = 4,
    parameter int PE = 6
) (
    // system clock
    input logic clk_i,
    // enables from the block
    input logic int_en_i,
    input logic ext_en_i,
    // oscillator levels
    output logic int_clk_o,
    output logic ext_clk_o
);
    int ci = 0;
    int ce = 0;

    // outputs known before the first edge
    initial begin
        int_clk_o = 1'b0;
        ext_clk_o = 1'b0;
    end

    // periods are scaled down; a stopped oscillator rests low and restarts in phase
    always @(posedge clk_i) begin
        ci <= int_en_i ? (ci + 1) % PI : 0;
        ce <= ext_en_i ? (ce + 1) % PE : 0;
        int_clk_o <= int_en_i && (ci >= PI / 2);
        ext_clk_o <= ext_en_i && (ce >= PE / 2);
    end
endmodule : mcs_osc_model
